// ==== core/scg_divider.v ====
// bit-period divider: bit start and bit centre strobes for the serial clock
`timescale 1ns/10ps
module scg_divider (
    // clock and reset
    input  wire       core_clk_in,
    input  wire       reset_in,
    // control
    input  wire       run_in,
    input  wire       clear_in,
    input  wire [2:0] rate_in,
    // strobes
    output reg        bit_start_out,
    output reg        bit_mid_out
);

`include "scg_regs.vh"

reg  [`SCG_CNT_W-1:0] cnt_reg;
reg  [`SCG_CNT_W-1:0] last_cnt;
reg  [`SCG_CNT_W-1:0] mid_cnt;
wire                  wrap;

// terminal count and centre point for each ratio
always @* begin
    last_cnt = 4'h0;
    mid_cnt  = 4'h0;
    case (rate_in)
        `SCG_RATE_DIV2: begin
            last_cnt = 4'h1;
            mid_cnt  = 4'h1;
        end
        `SCG_RATE_DIV4: begin
            last_cnt = 4'h3;
            mid_cnt  = 4'h2;
        end
        `SCG_RATE_DIV8: begin
            last_cnt = 4'h7;
            mid_cnt  = 4'h4;
        end
        `SCG_RATE_DIV16: begin
            last_cnt = 4'hF;
            mid_cnt  = 4'h8;
        end
        default: begin
            last_cnt = 4'h0;
            mid_cnt  = 4'h0;
        end
    endcase
end

assign wrap = (cnt_reg >= last_cnt);

// a stopped or cleared divider restarts at the top of a bit
always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
        cnt_reg       <= 4'h0;
        bit_start_out <= 1'b0;
        bit_mid_out   <= 1'b0;
    end else if (!run_in || clear_in) begin
        cnt_reg       <= 4'h0;
        bit_start_out <= 1'b0;
        bit_mid_out   <= 1'b0;
    end else begin
        cnt_reg       <= wrap ? 4'h0 : cnt_reg + 4'h1;
        bit_start_out <= (cnt_reg == 4'h0);
        // divide by one has no centre edge inside the core clock period
        bit_mid_out   <= (rate_in != `SCG_RATE_DIV1) && (cnt_reg == mid_cnt);
    end
end

endmodule // scg_divider

// ==== core/scg_regs.vh ====
// register indices, field positions, reset values and codes for the serial clock generator
`ifndef SCG_REGS_VH
`define SCG_REGS_VH

// register indices; the byte address on the bus is four times the index
`define SCG_IDX_CLK_CTRL     16'hF803
`define SCG_IDX_SYNC_EN      16'hF802
`define SCG_IDX_STATUS       16'hF80F
`define SCG_ADDR_W           18

// serial_clock_control fields
`define SCG_CTRL_W           16
`define SCG_CTRL_RESET       16'h0000
`define SCG_CTRL_HOLD_BIT    5
`define SCG_CTRL_CLREN_BIT   4
`define SCG_CTRL_POL_BIT     3
`define SCG_CTRL_RATE_HI     2
`define SCG_CTRL_RATE_LO     0
`define SCG_CTRL_USED_MASK   16'h003F

// serial_sync_enable: per-channel serial-output sync-reset enables
`define SCG_SYNC_CH0_BIT     24
`define SCG_SYNC_CH1_BIT     16
`define SCG_SYNC_CH2_BIT     8
`define SCG_SYNC_CH3_BIT     0
`define SCG_SYNC_RESET       4'h0

// serial_clock_status fields
`define SCG_STAT_HOLD_BIT    0
`define SCG_STAT_RUN_BIT     1
`define SCG_STAT_CLK_BIT     2

// rate codes
`define SCG_RATE_OFF         3'h0
`define SCG_RATE_DIV1        3'h1
`define SCG_RATE_DIV2        3'h2
`define SCG_RATE_DIV4        3'h3
`define SCG_RATE_DIV8        3'h4
`define SCG_RATE_DIV16       3'h5

`define SCG_CNT_W            4

`endif

// ==== core/scg_top.v ====
// serial clock generator: control registers on Avalon-MM and bit clock logic
//
// Function
// - rate code 000 off, 001-101 divide 1..16
// - bit 5 holds clock after reset until sync
// - bit 4 lets sync clear the divider
// - clear needs any channel sync-reset enable set
// - polarity 1: rising edge at bit centre
// - polarity 0: falling edge at bit centre
// - channel sync enable resets its serial output
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "scg_regs.vh"
module scg_top (
    // clock and reset
    input  wire                   core_clk_in,
    input  wire                   reset_in,
    // avalon-mm slave
    input  wire [`SCG_ADDR_W-1:0] avs_address_in,
    input  wire                   avs_read_in,
    input  wire                   avs_write_in,
    input  wire [3:0]             avs_byteenable_in,
    input  wire [31:0]            avs_writedata_in,
    output reg  [31:0]            avs_readdata_out,
    output reg                    avs_waitrequest_out,
    // sync input
    input  wire                   sync_input_pulse_in,
    // serial clock outputs
    output reg                    serial_clk_out,
    output reg                    bit_start_out,
    output reg                    bit_mid_out,
    // per-channel serial output block resets, channel 0 in bit 0
    output reg  [3:0]             chan_serial_reset_out
);

localparam [`SCG_ADDR_W-1:0] ADDR_CTRL = {`SCG_IDX_CLK_CTRL, 2'b00};
localparam [`SCG_ADDR_W-1:0] ADDR_SYNC = {`SCG_IDX_SYNC_EN, 2'b00};
localparam [`SCG_ADDR_W-1:0] ADDR_STAT = {`SCG_IDX_STATUS, 2'b00};

// bus handshake states
localparam [0:0] BUS_IDLE = 1'b0;
localparam [0:0] BUS_ACK  = 1'b1;

reg  [0:0]              bus_state_reg;
reg  [`SCG_CTRL_W-1:0]  ctrl_reg;
reg  [3:0]              sync_en_reg;
reg                     hold_reg;
reg  [31:0]             read_next;
reg  [`SCG_CTRL_W-1:0]  ctrl_next;
reg  [3:0]              sync_en_next;

wire                    access;
wire [31:0]             lane_mask;
wire [31:0]             wdata_ctrl;
wire [2:0]              rate;
wire                    polarity;
wire                    rate_valid;
wire                    run;
wire                    div_clear;
wire                    div_start;
wire                    div_mid;
wire [3:0]              chan_reset_next;

// a request still standing in BUS_ACK is the one being answered, so it
// must not be taken a second time
assign access = (avs_read_in || avs_write_in) && (bus_state_reg == BUS_IDLE);

genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
        assign lane_mask[lane*8 +: 8] = {8{avs_byteenable_in[lane]}};
    end
endgenerate

// keep unaddressed byte lanes of the control register
assign wdata_ctrl = ({16'h0000, ctrl_reg} & ~lane_mask)
                  | (avs_writedata_in & lane_mask);

// register write decode; the write lands on the taking edge, so a read
// issued right after the acknowledge already sees it
always @* begin
    ctrl_next    = ctrl_reg;
    sync_en_next = sync_en_reg;
    if (access && avs_write_in) begin
        if (avs_address_in == ADDR_CTRL) begin
            ctrl_next = wdata_ctrl[`SCG_CTRL_W-1:0] & `SCG_CTRL_USED_MASK;
        end else if (avs_address_in == ADDR_SYNC) begin
            // channel 0 enable sits in the top byte lane
            if (avs_byteenable_in[3]) begin
                sync_en_next[0] = avs_writedata_in[`SCG_SYNC_CH0_BIT];
            end
            if (avs_byteenable_in[2]) begin
                sync_en_next[1] = avs_writedata_in[`SCG_SYNC_CH1_BIT];
            end
            if (avs_byteenable_in[1]) begin
                sync_en_next[2] = avs_writedata_in[`SCG_SYNC_CH2_BIT];
            end
            if (avs_byteenable_in[0]) begin
                sync_en_next[3] = avs_writedata_in[`SCG_SYNC_CH3_BIT];
            end
        end
    end
end

// register read decode; unmapped addresses read zero
always @* begin
    read_next = 32'h0000_0000;
    if (avs_address_in == ADDR_CTRL) begin
        read_next[`SCG_CTRL_W-1:0] = ctrl_reg;
    end else if (avs_address_in == ADDR_SYNC) begin
        read_next[`SCG_SYNC_CH0_BIT] = sync_en_reg[0];
        read_next[`SCG_SYNC_CH1_BIT] = sync_en_reg[1];
        read_next[`SCG_SYNC_CH2_BIT] = sync_en_reg[2];
        read_next[`SCG_SYNC_CH3_BIT] = sync_en_reg[3];
    end else if (avs_address_in == ADDR_STAT) begin
        read_next[`SCG_STAT_HOLD_BIT] = hold_reg;
        read_next[`SCG_STAT_RUN_BIT]  = run;
        read_next[`SCG_STAT_CLK_BIT]  = serial_clk_out;
    end
end

// one wait state: answer at the edge after the request is seen
always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
        bus_state_reg       <= BUS_IDLE;
        avs_waitrequest_out <= 1'b1;
        avs_readdata_out    <= 32'h0000_0000;
        ctrl_reg            <= `SCG_CTRL_RESET;
        sync_en_reg         <= `SCG_SYNC_RESET;
    end else begin
        ctrl_reg    <= ctrl_next;
        sync_en_reg <= sync_en_next;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (access) begin
                    bus_state_reg       <= BUS_ACK;
                    avs_waitrequest_out <= 1'b0;
                    if (avs_read_in) begin
                        avs_readdata_out <= read_next;
                    end
                end
            end
            default: begin
                bus_state_reg       <= BUS_IDLE;
                avs_waitrequest_out <= 1'b1;
            end
        endcase
    end
end

assign rate     = ctrl_reg[`SCG_CTRL_RATE_HI:`SCG_CTRL_RATE_LO];
assign polarity = ctrl_reg[`SCG_CTRL_POL_BIT];

// undefined codes stop the clock rather than guess a ratio;
// software must not rely on that
assign rate_valid = (rate >= `SCG_RATE_DIV1) && (rate <= `SCG_RATE_DIV16);

// hold flag: armed only by hardware reset, dropped by the first sync
// setting bit 5 later does not re-arm it
always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
        hold_reg <= 1'b1;
    end else if (sync_input_pulse_in) begin
        hold_reg <= 1'b0;
    end
end

assign run = rate_valid && !(ctrl_reg[`SCG_CTRL_HOLD_BIT] && hold_reg);

// sync clears the divider only if some channel asks for it
assign div_clear = sync_input_pulse_in
                 && ctrl_reg[`SCG_CTRL_CLREN_BIT]
                 && (|sync_en_reg);

scg_divider u_divider (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .run_in        (run),
    .clear_in      (div_clear),
    .rate_in       (rate),
    .bit_start_out (div_start),
    .bit_mid_out   (div_mid)
);

// first half of a bit sits at the opposite level, so the centre edge
// goes the way polarity asks; divide by one cannot be shown on a flop
// and leaves the pin at its idle level, with bit_start every cycle
always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
        serial_clk_out <= 1'b1;
        bit_start_out  <= 1'b0;
        bit_mid_out    <= 1'b0;
    end else begin
        // the divider may still hold a strobe from its last running
        // cycle; gating keeps it from leaking out after a stop
        bit_start_out <= div_start && run;
        bit_mid_out   <= div_mid && run;
        if (!run || div_start) begin
            serial_clk_out <= ~polarity;
        end else if (div_mid) begin
            serial_clk_out <= polarity;
        end
    end
end

generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_chan
        assign chan_reset_next[lane] = sync_input_pulse_in
                                     && sync_en_reg[lane];
    end
endgenerate

// one reset pulse per high sync cycle, a cycle after the sync edge
always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
        chan_serial_reset_out <= 4'h0;
    end else begin
        chan_serial_reset_out <= chan_reset_next;
    end
end

endmodule // scg_top

// ==== dv/scg_rx_model.sv ====
// downstream receiver model: counts bit-centre clock edges
`timescale 1ns/10ps
module scg_rx_model (
    // clock and reset
    input  wire        core_clk_in,
    input  wire        reset_in,
    // serial link
    input  wire        pol_in,
    input  wire        serial_clk_in,
    output reg  [15:0] edge_cnt_out
);
    reg last_reg;
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            last_reg <= 1'b1;
            edge_cnt_out <= 16'h0000;
        end else begin
            last_reg <= serial_clk_in;
            // data is sampled on the edge that lands at the bit centre
            if (serial_clk_in == pol_in && last_reg != pol_in)
                edge_cnt_out <= edge_cnt_out + 16'h0001;
        end
    end
endmodule // scg_rx_model

// ==== dv/scg_top_sva.sv ====
// port assertions for the serial clock generator
`timescale 1ns/10ps
`include "scg_regs.vh"
module scg_top_chk (
    // clock and reset
    input wire                   core_clk_in,
    input wire                   reset_in,
    // avalon-mm
    input wire [`SCG_ADDR_W-1:0] avs_address_in,
    input wire                   avs_read_in,
    input wire                   avs_write_in,
    input wire [3:0]             avs_byteenable_in,
    input wire [31:0]            avs_writedata_in,
    input wire [31:0]            avs_readdata_out,
    input wire                   avs_waitrequest_out,
    // sync and serial clock
    input wire                   sync_input_pulse_in,
    input wire                   serial_clk_out,
    input wire                   bit_start_out,
    input wire                   bit_mid_out,
    input wire [3:0]             chan_serial_reset_out
);
    // the ctl_reg and en_reg shadows lag the design by a cycle, so the checks allow for it; held_reg tracks the hold flag in the same cycle
    reg  [5:0] ctl_reg;
    reg  [3:0] en_reg;
    reg        held_reg;
    wire       ack = avs_write_in & ~avs_waitrequest_out;
    wire [2:0] rate = ctl_reg[2:0];
    wire       run = rate > 3'h1 && rate < 3'h6;
    wire       stop = rate == 3'h0 || rate > 3'h5;
    always @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_reg <= 6'h00;
            en_reg <= 4'h0;
            held_reg <= 1'b1;
        end else begin
            if (sync_input_pulse_in)
                held_reg <= 1'b0;
            if (ack && avs_address_in == 18'h3E00C && avs_byteenable_in[0])
                ctl_reg <= avs_writedata_in[5:0];
            if (ack && avs_address_in == 18'h3E008) begin
                if (avs_byteenable_in[3])
                    en_reg[0] <= avs_writedata_in[24];
                if (avs_byteenable_in[2])
                    en_reg[1] <= avs_writedata_in[16];
                if (avs_byteenable_in[1])
                    en_reg[2] <= avs_writedata_in[8];
                if (avs_byteenable_in[0])
                    en_reg[3] <= avs_writedata_in[0];
            end
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wait_pulse_a: assert property (!avs_waitrequest_out |=>
        avs_waitrequest_out) else $error("ack too long");
    ack_bound_a: assert property ((avs_read_in || avs_write_in) |->
        ##[0:2] !avs_waitrequest_out) else $error("no ack");
    rate_off_a: assert property (stop |=> !bit_start_out && !bit_mid_out)
        else $error("strobe while stopped");
    hold_stop_a: assert property (held_reg && ctl_reg[5] |->
        !bit_start_out && !bit_mid_out) else $error("runs while held");
    mid_level_a: assert property (bit_mid_out |->
        serial_clk_out == ctl_reg[3]) else $error("centre level");
    start_level_a: assert property (bit_start_out |->
        serial_clk_out == !ctl_reg[3]) else $error("start level");
    sync_clear_a: assert property ((ctl_reg[4] && |en_reg && run &&
        sync_input_pulse_in ##1 !sync_input_pulse_in) |->
        ##1 !bit_start_out && !bit_mid_out ##1 bit_start_out)
        else $error("divider not cleared");
    chan_rst_a: assert property (1'b1 |-> chan_serial_reset_out ==
        ($past(sync_input_pulse_in) ? en_reg : 4'h0))
        else $error("channel reset");
endmodule // scg_top_chk

bind scg_top scg_top_chk u_scg_top_chk (
    .core_clk_in, .reset_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .sync_input_pulse_in,
    .serial_clk_out, .bit_start_out, .bit_mid_out, .chan_serial_reset_out
);

// ==== dv/scg_top_tb.sv ====
// self-checking bench for the serial clock generator
`timescale 1ns/10ps
`include "scg_regs.vh"
module scg_top_tb;
    localparam [17:0] CTRL = 18'h3E00C;
    localparam [17:0] SEN  = 18'h3E008;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [17:0] adr = 18'h00000;
    reg         rd_q = 1'b0;
    reg         wr_q = 1'b0;
    reg  [31:0] wd = 32'h00000000;
    reg         sync = 1'b0;
    reg         pol = 1'b0;
    reg  [3:0]  be = 4'hF;
    wire [31:0] rdata;
    wire        wreq, sclk, bstart, bmid;
    wire [3:0]  chr;
    wire [15:0] ecnt;
    reg  [31:0] rv, s0, e0, m0;
    reg  [31:0] starts = 32'h00000000;
    reg  [31:0] mids = 32'h00000000;
    integer     err_total = 0, total_checks = 0, k, n;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (bstart === 1'b1) starts <= starts + 1;
    always @(posedge clk) if (bmid === 1'b1) mids <= mids + 1;
    scg_top u_scg_top (.core_clk_in(clk), .reset_in(rst),
        .avs_address_in(adr), .avs_read_in(rd_q), .avs_write_in(wr_q),
        .avs_byteenable_in(be), .avs_writedata_in(wd),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .sync_input_pulse_in(sync), .serial_clk_out(sclk),
        .bit_start_out(bstart), .bit_mid_out(bmid),
        .chan_serial_reset_out(chr));
    scg_rx_model u_scg_rx_model (.core_clk_in(clk), .reset_in(rst),
        .pol_in(pol), .serial_clk_in(sclk), .edge_cnt_out(ecnt));
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e, input string nm);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // request held until waitrequest is sampled low
    task bus(input w, input [17:0] a, input [31:0] d);
        begin
            @(posedge clk);
            adr <= a;
            wd <= d;
            wr_q <= w;
            rd_q <= !w;
            do @(posedge clk); while (wreq !== 1'b0);
            rv = rdata;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end
    endtask
    // counts over 64 cycles, so every ratio fits a whole number of bits
    task win(input [31:0] es, input [31:0] ee);
        begin
            repeat (8) @(posedge clk);
            #1 s0 = starts;
            e0 = ecnt;
            m0 = mids;
            repeat (64) @(posedge clk);
            #1 chk(starts - s0, es, "bit starts");
            chk(ecnt - e0, ee, "centre edges");
            chk(mids - m0, ee, "bit centres");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, CTRL, 0);
        chk(rv, 32'h00000000, "ctrl reset");
        bus(1, CTRL, 32'hFFFFFFFF);
        bus(0, CTRL, 0);
        chk(rv, 32'h0000003F, "ctrl bits");
        bus(1, SEN, 32'hFFFFFFFF);
        bus(0, SEN, 0);
        chk(rv, 32'h01010101, "enable bits");
        be <= 4'h1;
        bus(1, SEN, 0);
        be <= 4'hF;
        bus(0, SEN, 0);
        chk(rv, 32'h01010100, "lane write");
        bus(1, 18'h3E010, 32'hFFFFFFFF);
        bus(0, 18'h3E010, 0);
        chk(rv, 32'h00000000, "unmapped");
        bus(1, SEN, 0);
        bus(1, CTRL, 32'h22);
        win(0, 0);
        bus(0, 18'h3E03C, 0);
        chk(rv, 32'h00000005, "status held");
        @(posedge clk) sync <= 1'b1;
        @(posedge clk) sync <= 1'b0;
        win(32, 32);
        bus(0, 18'h3E03C, 0);
        chk(rv & 32'h3, 32'h2, "status run");
        for (k = 0; k < 16; k = k + 1) begin
            @(posedge clk) pol <= k[3];
            bus(1, CTRL, k);
            n = k % 8;
            win(n == 1 ? 64 : (n > 1 && n < 6) ? 64 >> (n - 1) : 0,
                (n > 1 && n < 6) ? 64 >> (n - 1) : 0);
            if (n == 0 || n > 5)
                chk(sclk, !pol, "idle level");
        end
        for (k = 0; k < 3; k = k + 1) begin
            bus(1, SEN, k == 2 ? 0 : 32'h01000001);
            bus(1, CTRL, k == 1 ? 32'h05 : 32'h15);
            do begin @(posedge clk); #1; end while (bstart !== 1'b1);
            @(posedge clk) sync <= 1'b1;
            @(posedge clk) sync <= 1'b0;
            #1 chk(chr, k == 2 ? 0 : 4'h9, "channel resets");
            n = 1;
            do begin @(posedge clk); #1; n = n + 1; end
            while (bstart !== 1'b1);
            chk(n, k == 0 ? 3 : 15, "sync to start");
        end
        finish_test;
    end
    initial begin
        #250000;
        err_total = err_total + 1;
        finish_test;
    end
endmodule // scg_top_tb
